// [mtu_pkg.sv]
// Shared constants, types and helpers of the multimode timer unit.
// Assumes byte addressing on the register bus, one 32-bit word each.
package mtu_pkg;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL_A  = 6'h00;
  localparam logic [5:0] OFS_CTRL_B  = 6'h04;
  localparam logic [5:0] OFS_CTRL_CD = 6'h08;
  localparam logic [5:0] OFS_DATA_A  = 6'h0C;
  localparam logic [5:0] OFS_DATA_B  = 6'h10;
  localparam logic [5:0] OFS_DATA_C  = 6'h14;
  localparam logic [5:0] OFS_DATA_D  = 6'h18;
  localparam logic [5:0] OFS_EDGE    = 6'h1C;
  localparam logic [5:0] OFS_STATUS  = 6'h20;
  localparam logic [5:0] OFS_MASK    = 6'h24;
  localparam logic [5:0] OFS_AUX     = 6'h28;

  // Field positions
  localparam int CTRL_CLR_BIT   = 4;
  localparam int CD_THIRD_LSB   = 4;
  localparam int CD_FOURTH_LSB  = 0;
  localparam int ST_LINE_FOUR   = 4;
  localparam int ST_LINE_THREE  = 5;

  // Reset values
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [2:0] CDMODE_RST = 3'h0;
  localparam logic [1:0] EDGE_RST   = 2'h0;
  localparam logic [5:0] INT_RST    = 6'h00;
  // Edge detector history matches line level while in reset
  localparam logic [1:0] PREV_RST   = 2'h3;

  // Counter values
  localparam logic [7:0] CNT_LAST   = 8'h01;
  localparam int         TCLK_DIV   = 4;

  typedef enum logic [1:0] {
    TM_STOP  = 2'b00,
    TM_DELAY = 2'b01,
    TM_EVENT = 2'b10,
    TM_PULSE = 2'b11
  } tmode_t;

  // Prescale divisor for a 3-bit selector
  function automatic logic [7:0] divisor(input logic [2:0] sel);
    case (sel)
      3'h1:    divisor = 8'h04;
      3'h2:    divisor = 8'h0A;
      3'h3:    divisor = 8'h10;
      3'h4:    divisor = 8'h32;
      3'h5:    divisor = 8'h40;
      3'h6:    divisor = 8'h64;
      3'h7:    divisor = 8'hC8;
      default: divisor = 8'h01;
    endcase
  endfunction : divisor

  // Mode of a first/second timer control nibble
  function automatic tmode_t abMode(input logic [3:0] c);
    if (c == 4'h0)
      abMode = TM_STOP;
    else if (c == 4'h8)
      abMode = TM_EVENT;
    else if (c[3])
      abMode = TM_PULSE;
    else
      abMode = TM_DELAY;
  endfunction : abMode

endpackage : mtu_pkg

// [timer_channel.sv]
// One 8-bit down-counting timer with prescaler and toggling output.
// Assumes tick is a one-cycle timer clock enable, evPulse a one-cycle
// event strobe, both on mclk.
`timescale 1ns/100ps
module timer_channel (
  input  wire logic           mclk,
  input  wire logic           nrst,
  input  wire logic           tick,
  input  wire mtu_pkg::tmode_t tmode,
  input  wire logic [2:0]     psSel,
  input  wire logic           gateOn,
  input  wire logic           evPulse,
  input  wire logic           dataWr,
  input  wire logic [7:0]     wrData,
  input  wire logic           outClear,
  output logic      [7:0]     count,
  output logic                timeout,
  output logic                timerOut
);

  logic [7:0] psCntReg;
  logic [7:0] reloadReg;
  logic [7:0] divNow;
  logic       run;
  logic       psPulse;
  logic       countPulse;

  assign divNow = mtu_pkg::divisor(psSel);
  assign run = (tmode == mtu_pkg::TM_DELAY) ||
               ((tmode == mtu_pkg::TM_PULSE) && gateOn); // R16 R4
  assign psPulse = tick && run && (psCntReg == divNow - 8'h01); // R1
  assign countPulse = (tmode == mtu_pkg::TM_EVENT) ? evPulse // R8
                                                   : psPulse;
  assign timeout = countPulse && (count == mtu_pkg::CNT_LAST); // R17

  // Prescaler, residue lost when stopped or bypassed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      psCntReg <= 8'h00;
    else if (tmode == mtu_pkg::TM_STOP || tmode == mtu_pkg::TM_EVENT)
      psCntReg <= 8'h00; // R8
    else if (psPulse)
      psCntReg <= 8'h00; // R1
    else if (tick && run)
      psCntReg <= psCntReg + 8'h01;
  end

  // Data register and counter keep their content through reset
  always_ff @(posedge mclk) begin
    if (dataWr)
      reloadReg <= wrData; // R15
  end

  always_ff @(posedge mclk) begin
    if (dataWr && tmode == mtu_pkg::TM_STOP)
      count <= wrData;
    else if (countPulse && count == mtu_pkg::CNT_LAST)
      count <= reloadReg; // R17 R7
    else if (countPulse)
      count <= count - 8'h01; // R8
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      timerOut <= 1'b0; // R12
    else if (outClear)
      timerOut <= 1'b0; // R14
    else if (timeout)
      timerOut <= ~timerOut; // R13
  end

  property p_reload;
    @(posedge mclk) disable iff (!nrst)
      (countPulse && count == mtu_pkg::CNT_LAST && !dataWr) |=>
        (count == $past(reloadReg));
  endproperty
  a_reload: assert property (p_reload) // R17
    else $error("counter did not reload at terminal count");

  property p_toggle;
    @(posedge mclk) disable iff (!nrst)
      (timeout && !outClear) |=> (timerOut != $past(timerOut));
  endproperty
  a_toggle: assert property (p_toggle) // R13
    else $error("output did not toggle on time-out");

  property p_clear;
    @(posedge mclk) disable iff (!nrst)
      outClear |=> !timerOut;
  endproperty
  a_clear: assert property (p_clear) // R14
    else $error("output not held low by clear");

  property p_prescale;
    @(posedge mclk) disable iff (!nrst)
      (tmode == mtu_pkg::TM_DELAY) |-> (psCntReg < divNow);
  endproperty
  a_prescale: assert property (p_prescale) // R1
    else $error("prescaler passed its divisor");

  property p_event;
    @(posedge mclk) disable iff (!nrst)
      (tmode == mtu_pkg::TM_EVENT && evPulse && !dataWr &&
       count != mtu_pkg::CNT_LAST) |=> (count == $past(count) - 8'h01);
  endproperty
  a_event: assert property (p_event) // R8
    else $error("event did not decrement counter");

endmodule : timer_channel

// [multimode_timer_unit.sv]
// Four-timer unit: control registers, auxiliary input handling and
// interrupt status behind an Avalon-MM slave with waitrequest.
// Assumes auxiliary inputs are asynchronous pins; one clock, mclk.
//
// How it works
// (R1) Third/fourth mode: stop, then prescale 4..200
// (R2) Unused bits of third/fourth control read zero
// (R3) Pulse mode inverts the line interrupt edge
// (R4) Edge one: count high, interrupt on fall
// (R5) Leaving pulse mode restores normal interrupt edge
// (R6) Entering/leaving pulse mode may raise interrupt
// (R7) Running write loads at count 01
// (R8) Event mode bypasses prescaler, decrements per edge
// (R9) Edge change in event mode may count
// (R10) Event mode keeps normal line interrupt edge
// (R11) Source holds each level four timer clocks
// (R12) Reset drives all timer outputs low
// (R13) First/second outputs toggle on every time-out
// (R14) Output-clear write holds output low
// (R15) Reset leaves data and counters unchanged
// (R16) Pulse mode: aux level gates the timer
// (R17) Count 01 reloads and emits one time-out
// (R18) Aux inputs synchronised before edge detection
`timescale 1ns/100ps
module multimode_timer_unit #(
  parameter int TIMER_CLK_DIV = mtu_pkg::TCLK_DIV
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [5:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  input  wire logic        timerAAuxInput,
  input  wire logic        timerBAuxInput,
  output logic             timerAOut,
  output logic             timerBOut,
  output logic             timerCOut,
  output logic             timerDOut,
  output logic             irq
);

  logic [3:0] firstCtrlReg;
  logic [3:0] secondCtrlReg;
  logic [2:0] thirdModeReg;
  logic [2:0] fourthModeReg;
  logic [1:0] edgeSelectReg;
  logic [5:0] intStatusReg;
  logic [5:0] intMaskReg;
  logic       ackReg;
  logic [1:0] auxMetaReg;
  logic [1:0] auxSyncReg;
  logic [1:0] lineSigPrevReg;
  logic [1:0] evSigPrevReg;
  logic [7:0] tickCntReg;
  logic       tick;
  logic       wrEn;
  logic       rdEn;
  logic       lane0;
  logic [1:0] pulseMode;
  logic [1:0] activeLevel;
  logic [1:0] lineSig;
  logic [1:0] lineRise;
  logic [1:0] evRise;
  logic [5:0] intEvents;
  logic [7:0] cdCtrlView;

  mtu_pkg::tmode_t tmodes [4];
  logic [2:0] psSels   [4];
  logic [7:0] counts   [4];
  logic [3:0] dataWrs;
  logic [3:0] clears;
  logic [3:0] gates;
  logic [3:0] evPulses;
  logic [3:0] timeouts;
  logic [3:0] outs;

  // Bus handshake: every access answered on its second cycle
  assign avsWaitrequest = (avsRead || avsWrite) && !ackReg;
  assign wrEn  = avsWrite && ackReg;
  assign rdEn  = avsRead && ackReg;
  assign lane0 = avsByteenable[0];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      ackReg <= 1'b0;
    else
      ackReg <= (avsRead || avsWrite) && !ackReg;
  end

  // Timer clock enable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      tickCntReg <= 8'h00;
    else if (tick)
      tickCntReg <= 8'h00;
    else
      tickCntReg <= tickCntReg + 8'h01;
  end
  assign tick = (tickCntReg == 8'(TIMER_CLK_DIV - 1));

  // Control registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      firstCtrlReg  <= mtu_pkg::CTRL_RST;
      secondCtrlReg <= mtu_pkg::CTRL_RST;
      thirdModeReg  <= mtu_pkg::CDMODE_RST;
      fourthModeReg <= mtu_pkg::CDMODE_RST;
    end else if (wrEn && lane0) begin
      case (avsAddress)
        mtu_pkg::OFS_CTRL_A: firstCtrlReg  <= avsWritedata[3:0];
        mtu_pkg::OFS_CTRL_B: secondCtrlReg <= avsWritedata[3:0];
        mtu_pkg::OFS_CTRL_CD: begin
          thirdModeReg  <= avsWritedata[mtu_pkg::CD_THIRD_LSB +: 3];
          fourthModeReg <= avsWritedata[mtu_pkg::CD_FOURTH_LSB +: 3];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      edgeSelectReg <= mtu_pkg::EDGE_RST;
    else if (wrEn && lane0 && avsAddress == mtu_pkg::OFS_EDGE)
      edgeSelectReg <= avsWritedata[1:0];
  end

  // Output clear acts for the whole write access
  assign clears[0] = avsWrite && lane0 &&
                     avsAddress == mtu_pkg::OFS_CTRL_A &&
                     avsWritedata[mtu_pkg::CTRL_CLR_BIT]; // R14
  assign clears[1] = avsWrite && lane0 &&
                     avsAddress == mtu_pkg::OFS_CTRL_B &&
                     avsWritedata[mtu_pkg::CTRL_CLR_BIT]; // R14
  assign clears[3:2] = 2'b00;

  assign dataWrs[0] = wrEn && lane0 && avsAddress == mtu_pkg::OFS_DATA_A;
  assign dataWrs[1] = wrEn && lane0 && avsAddress == mtu_pkg::OFS_DATA_B;
  assign dataWrs[2] = wrEn && lane0 && avsAddress == mtu_pkg::OFS_DATA_C;
  assign dataWrs[3] = wrEn && lane0 && avsAddress == mtu_pkg::OFS_DATA_D;

  // Mode decode
  assign tmodes[0] = mtu_pkg::abMode(firstCtrlReg);
  assign tmodes[1] = mtu_pkg::abMode(secondCtrlReg);
  assign tmodes[2] = (thirdModeReg == 3'h0) ? mtu_pkg::TM_STOP
                                            : mtu_pkg::TM_DELAY; // R1
  assign tmodes[3] = (fourthModeReg == 3'h0) ? mtu_pkg::TM_STOP
                                             : mtu_pkg::TM_DELAY; // R1
  assign psSels[0] = firstCtrlReg[2:0];
  assign psSels[1] = secondCtrlReg[2:0];
  assign psSels[2] = thirdModeReg;
  assign psSels[3] = fourthModeReg;

  // Auxiliary input synchroniser
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      auxMetaReg <= 2'b00;
      auxSyncReg <= 2'b00;
    end else begin
      auxMetaReg <= {timerBAuxInput, timerAAuxInput};
      auxSyncReg <= auxMetaReg; // R18
    end
  end

  assign pulseMode[0] = (tmodes[0] == mtu_pkg::TM_PULSE);
  assign pulseMode[1] = (tmodes[1] == mtu_pkg::TM_PULSE);
  // Active level follows the edge bit
  assign activeLevel = auxSyncReg ^ ~edgeSelectReg; // R16
  // Line interrupt edge turned round in pulse mode
  assign lineSig  = activeLevel ^ pulseMode; // R3 R5 R10
  assign lineRise = lineSig & ~lineSigPrevReg; // R6
  assign evRise   = activeLevel & ~evSigPrevReg; // R8 R9

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lineSigPrevReg <= mtu_pkg::PREV_RST;
      evSigPrevReg   <= mtu_pkg::PREV_RST;
    end else begin
      lineSigPrevReg <= lineSig;
      evSigPrevReg   <= activeLevel;
    end
  end

  assign gates    = {2'b00, activeLevel}; // R16
  assign evPulses = {2'b00, evRise}; // R8

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_timer
      timer_channel u_timer (
        .mclk     (mclk),
        .nrst     (nrst),
        .tick     (tick),
        .tmode    (tmodes[i]),
        .psSel    (psSels[i]),
        .gateOn   (gates[i]),
        .evPulse  (evPulses[i]),
        .dataWr   (dataWrs[i]),
        .wrData   (avsWritedata[7:0]),
        .outClear (clears[i]),
        .count    (counts[i]),
        .timeout  (timeouts[i]),
        .timerOut (outs[i])
      );
    end
  endgenerate

  assign timerAOut = outs[0];
  assign timerBOut = outs[1];
  assign timerCOut = outs[2];
  assign timerDOut = outs[3];

  // Interrupt status, set wins over write-one-clear
  assign intEvents = {lineRise[1], lineRise[0], timeouts};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      intStatusReg <= mtu_pkg::INT_RST;
    else if (wrEn && lane0 && avsAddress == mtu_pkg::OFS_STATUS)
      intStatusReg <= (intStatusReg & ~avsWritedata[5:0]) | intEvents;
    else
      intStatusReg <= intStatusReg | intEvents;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      intMaskReg <= mtu_pkg::INT_RST;
    else if (wrEn && lane0 && avsAddress == mtu_pkg::OFS_MASK)
      intMaskReg <= avsWritedata[5:0];
  end

  assign irq = |(intStatusReg & intMaskReg);

  // Read data, unused bits zero
  assign cdCtrlView = {1'b0, thirdModeReg, 1'b0, fourthModeReg}; // R2

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      avsReaddata <= 32'h0000_0000;
    else if (avsRead && !ackReg) begin
      case (avsAddress)
        mtu_pkg::OFS_CTRL_A:  avsReaddata <= {28'h0, firstCtrlReg};
        mtu_pkg::OFS_CTRL_B:  avsReaddata <= {28'h0, secondCtrlReg};
        mtu_pkg::OFS_CTRL_CD: avsReaddata <= {24'h0, cdCtrlView};
        mtu_pkg::OFS_DATA_A:  avsReaddata <= {24'h0, counts[0]};
        mtu_pkg::OFS_DATA_B:  avsReaddata <= {24'h0, counts[1]};
        mtu_pkg::OFS_DATA_C:  avsReaddata <= {24'h0, counts[2]};
        mtu_pkg::OFS_DATA_D:  avsReaddata <= {24'h0, counts[3]};
        mtu_pkg::OFS_EDGE:    avsReaddata <= {30'h0, edgeSelectReg};
        mtu_pkg::OFS_STATUS:  avsReaddata <= {26'h0, intStatusReg};
        mtu_pkg::OFS_MASK:    avsReaddata <= {26'h0, intMaskReg};
        mtu_pkg::OFS_AUX:     avsReaddata <= {30'h0, auxSyncReg};
        default:              avsReaddata <= 32'h0000_0000;
      endcase
    end
  end

  property p_reset_low;
    @(posedge mclk) !nrst |-> (outs == 4'h0);
  endproperty
  a_reset_low: assert property (p_reset_low) // R12
    else $error("timer output high during reset");

  property p_cd_unused;
    @(posedge mclk) disable iff (!nrst)
      (rdEn && avsAddress == mtu_pkg::OFS_CTRL_CD) |->
        (avsReaddata[7] == 1'b0 && avsReaddata[3] == 1'b0);
  endproperty
  a_cd_unused: assert property (p_cd_unused) // R2
    else $error("unused control bit read as one");

  property p_pulse_fall;
    @(posedge mclk) disable iff (!nrst)
      (pulseMode[1] && $stable(pulseMode[1]) && edgeSelectReg[1] &&
       $stable(edgeSelectReg[1]) && $fell(auxSyncReg[1])) |=>
        intStatusReg[mtu_pkg::ST_LINE_THREE];
  endproperty
  a_pulse_fall: assert property (p_pulse_fall) // R4
    else $error("no line interrupt at end of pulse");

  property p_pulse_norise;
    @(posedge mclk) disable iff (!nrst)
      (pulseMode[1] && $stable(pulseMode[1]) && edgeSelectReg[1] &&
       $stable(edgeSelectReg[1]) && $rose(auxSyncReg[1])) |->
        !lineRise[1];
  endproperty
  a_pulse_norise: assert property (p_pulse_norise) // R3
    else $error("pulse mode interrupt on normal edge");

  property p_event_edge;
    @(posedge mclk) disable iff (!nrst)
      (tmodes[0] == mtu_pkg::TM_EVENT && $stable(tmodes[0]) &&
       edgeSelectReg[0] && $stable(edgeSelectReg[0]) &&
       $rose(auxSyncReg[0])) |=>
        intStatusReg[mtu_pkg::ST_LINE_FOUR];
  endproperty
  a_event_edge: assert property (p_event_edge) // R10
    else $error("event mode line interrupt missed");

  property p_gate;
    @(posedge mclk) disable iff (!nrst)
      (pulseMode[1] && !activeLevel[1] && !dataWrs[1]) |=>
        (counts[1] == $past(counts[1]));
  endproperty
  a_gate: assert property (p_gate) // R16
    else $error("gated timer counted while inactive");

endmodule : multimode_timer_unit

// [aux_source_model.sv]
// External signal source on the two auxiliary timer inputs.
// Assumes calls come from the bench just after a rising edge of mclk.
`timescale 1ns/100ps
module aux_source_model #(
  parameter int TIMER_CLK_DIV = 4,
  parameter int PERIOD_NS     = 8
) (
  input  wire logic mclk,
  output logic      auxA,
  output logic      auxB
);
  localparam int HOLD = 4 * TIMER_CLK_DIV + 2;

  time lastChange [2];

  initial begin
    auxA = 1'b0;
    auxB = 1'b0;
    lastChange[0] = 0;
    lastChange[1] = 0;
  end

  // Each level is held long enough to be seen as a transition
  task automatic drive(input bit b, input logic v);
    while ($time - lastChange[b] < HOLD * PERIOD_NS) @(posedge mclk);
    if (b)
      auxB <= v;
    else
      auxA <= v;
    lastChange[b] = $time;
  endtask : drive
endmodule : aux_source_model

// [multimode_timer_unit_tb.sv]
// Self-checking bench of the multimode timer unit.
// Assumes the aux source model and the design package are compiled first.
`timescale 1ns/100ps
module multimode_timer_unit_tb;
  localparam int DIV = 2;

  logic        mclk;
  logic        nrst;
  logic [5:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [3:0]  avsByteenable;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        irq;
  logic        auxA;
  logic        auxB;
  wire  [3:0]  outs;
  logic        wrqS;
  logic [31:0] rdS;
  logic [31:0] rdv;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;
  int          divs [8] = '{0, 4, 10, 16, 50, 64, 100, 200};

  multimode_timer_unit #(.TIMER_CLK_DIV(DIV)) dut_u (
    .mclk(mclk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .timerAAuxInput(auxA),
    .timerBAuxInput(auxB), .timerAOut(outs[0]), .timerBOut(outs[1]),
    .timerCOut(outs[2]), .timerDOut(outs[3]), .irq(irq)
  );

  aux_source_model #(.TIMER_CLK_DIV(DIV)) src_u (
    .mclk(mclk), .auxA(auxA), .auxB(auxB)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Values seen during the cycle that ends at the next rising edge
  always @(negedge mclk) begin
    wrqS = avsWaitrequest;
    rdS = avsReaddata;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task print_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wrqS !== 1'b0 && k < 64);
    rdv = rdS;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : acc

  task wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task rdChk(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdv, e);
  endtask : rdChk

  task waitN(input int c);
    repeat (c) @(posedge mclk);
  endtask : waitN

  // Cycles between two toggles of one timer output
  task automatic period(input int i, output int cnt);
    logic p;
    @(negedge mclk);
    p = outs[i];
    cnt = 0;
    while (outs[i] === p && cnt < 1000) begin
      @(negedge mclk);
      cnt++;
    end
    p = outs[i];
    cnt = 0;
    while (outs[i] === p && cnt < 1000) begin
      @(negedge mclk);
      cnt++;
    end
  endtask : period

  task pulseA(input int c);
    repeat (c) begin
      src_u.drive(1'b0, 1'b1);
      src_u.drive(1'b0, 1'b0);
    end
    waitN(10);
  endtask : pulseA

  initial begin
    nrst = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 6'h00;
    avsWritedata = 32'h00000000;
    avsByteenable = 4'hF;
    waitN(20);
    nrst <= 1'b1;
    @(negedge mclk);
    chk(outs, 32'h0);
    rdChk(mtu_pkg::OFS_CTRL_A, 32'h0);
    rdChk(mtu_pkg::OFS_CTRL_CD, 32'h0);
    rdChk(mtu_pkg::OFS_MASK, 32'h0);
    rdChk(6'h2C, 32'h0);
    wr(mtu_pkg::OFS_CTRL_CD, 8'hFF);
    rdChk(mtu_pkg::OFS_CTRL_CD, 32'h77);
    wr(mtu_pkg::OFS_CTRL_CD, 8'h00);
    wr(mtu_pkg::OFS_DATA_C, 8'h01);
    wr(mtu_pkg::OFS_DATA_D, 8'h01);
    wr(mtu_pkg::OFS_STATUS, 8'h3F);
    for (int c = 1; c < 8; c++) begin
      wr(mtu_pkg::OFS_CTRL_CD, {1'b0, c[2:0], 1'b0, c[2:0]});
      period(2, n);
      chk(n, divs[c] * DIV);
      period(3, n);
      chk(n, divs[c] * DIV);
    end
    wr(mtu_pkg::OFS_CTRL_CD, 8'h00);
    n = outs[3];
    waitN(450);
    chk(outs[3], n);
    acc(1'b0, mtu_pkg::OFS_STATUS, 8'h00);
    chk(rdv & 32'h0C, 32'h0C);
    @(negedge mclk);
    chk(irq, 32'h0);
    wr(mtu_pkg::OFS_MASK, 8'h08);
    @(negedge mclk);
    chk(irq, 32'h1);
    wr(mtu_pkg::OFS_STATUS, 8'h3F);
    @(negedge mclk);
    chk(irq, 32'h0);
    rdChk(mtu_pkg::OFS_STATUS, 32'h0);
    avsByteenable <= 4'hE;
    wr(mtu_pkg::OFS_EDGE, 8'h03);
    avsByteenable <= 4'hF;
    rdChk(mtu_pkg::OFS_EDGE, 32'h0);
    wr(mtu_pkg::OFS_EDGE, 8'h03);
    wr(mtu_pkg::OFS_DATA_A, 8'h03);
    wr(mtu_pkg::OFS_CTRL_A, 8'h08);
    wr(mtu_pkg::OFS_STATUS, 8'h3F);
    pulseA(2);
    rdChk(mtu_pkg::OFS_DATA_A, 32'h01);
    acc(1'b0, mtu_pkg::OFS_STATUS, 8'h00);
    chk(rdv[4], 32'h1);
    pulseA(1);
    rdChk(mtu_pkg::OFS_DATA_A, 32'h03);
    chk(outs[0], 32'h1);
    wr(mtu_pkg::OFS_CTRL_A, 8'h18);
    @(negedge mclk);
    chk(outs[0], 32'h0);
    rdChk(mtu_pkg::OFS_CTRL_A, 32'h08);
    pulseA(3);
    chk(outs[0], 32'h1);
    wr(mtu_pkg::OFS_DATA_B, 8'hFF);
    wr(mtu_pkg::OFS_CTRL_B, 8'h09);
    wr(mtu_pkg::OFS_STATUS, 8'h3F);
    src_u.drive(1'b1, 1'b1);
    waitN(20);
    acc(1'b0, mtu_pkg::OFS_STATUS, 8'h00);
    chk(rdv[5], 32'h0);
    waitN(57);
    src_u.drive(1'b1, 1'b0);
    waitN(10);
    acc(1'b0, mtu_pkg::OFS_STATUS, 8'h00);
    chk(rdv[5], 32'h1);
    acc(1'b0, mtu_pkg::OFS_DATA_B, 8'h00);
    chk(rdv >= 32'hF4 && rdv <= 32'hF6, 32'h1);
    waitN(40);
    rdChk(mtu_pkg::OFS_DATA_B, rdv);
    wr(mtu_pkg::OFS_CTRL_B, 8'h01);
    wr(mtu_pkg::OFS_STATUS, 8'h3F);
    src_u.drive(1'b1, 1'b1);
    waitN(10);
    acc(1'b0, mtu_pkg::OFS_STATUS, 8'h00);
    chk(rdv[5], 32'h1);
    rdChk(mtu_pkg::OFS_AUX, 32'h2);
    wr(mtu_pkg::OFS_CTRL_B, 8'h00);
    wr(mtu_pkg::OFS_DATA_C, 8'h5A);
    nrst <= 1'b0;
    waitN(3);
    @(negedge mclk);
    chk(outs, 32'h0);
    @(posedge mclk);
    nrst <= 1'b1;
    rdChk(mtu_pkg::OFS_DATA_C, 32'h5A);
    rdChk(mtu_pkg::OFS_DATA_A, 32'h03);
    print_verdict();
  end
endmodule : multimode_timer_unit_tb
